// ===== pwrc_pkg.sv
// package: register map, field positions and reset values of the power control registers
package pwrc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  // printed offsets are not all multiples of four: they are indices, byte address = 4 * index
  localparam logic [15:0] PWRC_IDX_LCD_REG   = 16'h50A3;
  localparam logic [15:0] PWRC_IDX_BOOST     = 16'h50A4;
  localparam logic [15:0] PWRC_IDX_CORE_REG  = 16'h5120;
  localparam int          PWRC_ADDR_W        = 18;
  localparam int          PWRC_REG_W         = 8;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PWRC_CORE_HLP_BIT   = 4;
  localparam int PWRC_FLASH_MODE_BIT = 0;
  localparam int PWRC_LCD_HLP_BIT    = 4;
  localparam int PWRC_SRC_SEL_BIT    = 1;
  localparam int PWRC_BOOST_ON_BIT   = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic PWRC_RST_CORE_HLP   = 1'b0;
  localparam logic PWRC_RST_FLASH_MODE = 1'b0;
  localparam logic PWRC_RST_LCD_HLP    = 1'b0;
  localparam logic PWRC_RST_SRC_SEL    = 1'b0;
  localparam logic PWRC_RST_BOOST_ON   = 1'b0;

  // ****************************************************************
  // analog control bundle
  // ****************************************************************
  typedef struct packed {
    logic core_heavy_load_protect;
    logic flash_voltage_mode;
    logic lcd_heavy_load_protect;
    logic lcd_source_select;
    logic booster_on;
  } pwrc_ctrl_t;
endpackage

// ===== pwrc_regs.sv
// power control register bank with classic Wishbone slave
// Behaviour
// - core reg bit4 heavy-load protect, reset 0
// - core reg bit0 flash voltage mode, reset 0
// - lcd reg bit4 heavy-load protect, reset 0
// - booster reg bit1 lcd source select, reset 0
// - booster reg bit0 booster on, reset 0
// - reserved bits read zero, written zero
// - each register is eight bits wide
//
// ****************************************************************
// overview
// ****************************************************************
// three eight-bit control registers sit behind a classic Wishbone slave.
// each register occupies the low byte lane of one aligned word; the word
// index equals the register offset, so the byte address is four times
// the offset and address bits 1 and 0 are ignored.
//
// bus timing: a request is taken on the rising edge that sees cyc and
// stb high while ack is low; ack rises on that same edge and stands for
// one cycle, so the master sees it one edge later and drops the strobe.
// a write lands on the taking edge, which is also the edge on which the
// analog control line moves. read data is registered and stands with
// ack only; at every other time the data bus is zero.
//
// writes with byte lane 0 disabled are acknowledged and dropped.
// unmapped words are acknowledged, read as zero and ignore writes.
// reserved bit positions are not stored, so they always read as zero.
//
// the hardware does not police the order in which software turns the
// booster on and selects the boosted source, nor any settle time: the
// regulators are analog, and a long cycle counter here would cost area
// for a duty that firmware already keeps.
//
module pwrc_regs
  import pwrc_pkg::*;
(
  input  wire logic                   CLK_I,
  input  wire logic                   SYS_RST_I,
  input  wire logic                   CYC_I,
  input  wire logic                   STB_I,
  input  wire logic                   WE_I,
  input  wire logic [PWRC_ADDR_W-1:0] ADR_I,
  input  wire logic [31:0]            DAT_I,
  input  wire logic [3:0]             SEL_I,
  output logic      [31:0]            DAT_O,
  output logic                        ACK_O,
  output logic                        CORE_HEAVY_LOAD_PROTECT_O,
  output logic                        FLASH_VOLTAGE_MODE_O,
  output logic                        LCD_HEAVY_LOAD_PROTECT_O,
  output logic                        LCD_SOURCE_SELECT_O,
  output logic                        BOOSTER_ON_O
);

  // ****************************************************************
  // decode
  // ****************************************************************
  // register index of a word address; registers live in byte lane 0
  function automatic logic [15:0] pwrc_index(input logic [PWRC_ADDR_W-1:0] a);
    pwrc_index = a[PWRC_ADDR_W-1:2];
  endfunction

  pwrc_ctrl_t  ctrl_r;
  logic        req;
  logic        wr_en;
  logic        lane0;
  logic        hit_core;
  logic        hit_lcd;
  logic        hit_boost;
  logic [7:0]  rd_byte;

  // a request is served once: ack pulses one cycle, then drops
  assign req       = CYC_I && STB_I && !ACK_O;
  assign lane0     = SEL_I[0];
  assign wr_en     = req && WE_I && lane0;
  assign hit_core  = (pwrc_index(ADR_I) == PWRC_IDX_CORE_REG);
  assign hit_lcd   = (pwrc_index(ADR_I) == PWRC_IDX_LCD_REG);
  assign hit_boost = (pwrc_index(ADR_I) == PWRC_IDX_BOOST);

  // ****************************************************************
  // control registers
  // ****************************************************************
  // core regulator control: writes to reserved bits are dropped
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_r.core_heavy_load_protect <= PWRC_RST_CORE_HLP;
      ctrl_r.flash_voltage_mode      <= PWRC_RST_FLASH_MODE;
    end else if (wr_en && hit_core) begin
      ctrl_r.core_heavy_load_protect <= DAT_I[PWRC_CORE_HLP_BIT];
      ctrl_r.flash_voltage_mode      <= DAT_I[PWRC_FLASH_MODE_BIT];
    end
  end

  // lcd regulator control
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_r.lcd_heavy_load_protect <= PWRC_RST_LCD_HLP;
    end else if (wr_en && hit_lcd) begin
      ctrl_r.lcd_heavy_load_protect <= DAT_I[PWRC_LCD_HLP_BIT];
    end
  end

  // booster control; write order and settle time are left to software
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_r.lcd_source_select <= PWRC_RST_SRC_SEL;
      ctrl_r.booster_on        <= PWRC_RST_BOOST_ON;
    end else if (wr_en && hit_boost) begin
      ctrl_r.lcd_source_select <= DAT_I[PWRC_SRC_SEL_BIT];
      ctrl_r.booster_on        <= DAT_I[PWRC_BOOST_ON_BIT];
    end
  end

  // analog outputs straight from the register bits
  assign CORE_HEAVY_LOAD_PROTECT_O = ctrl_r.core_heavy_load_protect;
  assign FLASH_VOLTAGE_MODE_O      = ctrl_r.flash_voltage_mode;
  assign LCD_HEAVY_LOAD_PROTECT_O  = ctrl_r.lcd_heavy_load_protect;
  assign LCD_SOURCE_SELECT_O       = ctrl_r.lcd_source_select;
  assign BOOSTER_ON_O              = ctrl_r.booster_on;

  // ****************************************************************
  // read path
  // ****************************************************************
  // eight-bit images with reserved positions forced to zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_core) begin
      rd_byte[PWRC_CORE_HLP_BIT]   = ctrl_r.core_heavy_load_protect;
      rd_byte[PWRC_FLASH_MODE_BIT] = ctrl_r.flash_voltage_mode;
    end else if (hit_lcd) begin
      rd_byte[PWRC_LCD_HLP_BIT] = ctrl_r.lcd_heavy_load_protect;
    end else if (hit_boost) begin
      rd_byte[PWRC_SRC_SEL_BIT]  = ctrl_r.lcd_source_select;
      rd_byte[PWRC_BOOST_ON_BIT] = ctrl_r.booster_on;
    end
  end

  // ack one cycle after request; unmapped reads return zero, writes ignored
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= req;
      DAT_O <= (req && !WE_I) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  core_write_a: assert property (wr_en && hit_core |=> FLASH_VOLTAGE_MODE_O == $past(DAT_I[0])
    && CORE_HEAVY_LOAD_PROTECT_O == $past(DAT_I[4])) else $error("core write lost");
  core_hold_a: assert property (!(wr_en && hit_core) |=> $stable(FLASH_VOLTAGE_MODE_O)
    && $stable(CORE_HEAVY_LOAD_PROTECT_O)) else $error("core bits changed");
  lcd_write_a: assert property (wr_en && hit_lcd |=> LCD_HEAVY_LOAD_PROTECT_O == $past(DAT_I[4]))
    else $error("lcd write lost");
  src_write_a: assert property (wr_en && hit_boost |=> LCD_SOURCE_SELECT_O == $past(DAT_I[1]))
    else $error("source write lost");
  boost_write_a: assert property (wr_en && hit_boost |=> BOOSTER_ON_O == $past(DAT_I[0]))
    else $error("booster write lost");
  read_resv_a: assert property (ACK_O |-> DAT_O[31:5] == 27'h0 && DAT_O[3:2] == 2'h0)
    else $error("reserved bits nonzero");
  read_width_a: assert property (req && !WE_I && hit_boost |=> DAT_O[7:2] == 6'h00
    && DAT_O[1] == LCD_SOURCE_SELECT_O) else $error("booster read wrong");
  ack_pulse_a: assert property (req |=> ACK_O ##1 !ACK_O) else $error("ack not one pulse");
  lcd_hold_a: assert property (!(wr_en && hit_lcd) |=> $stable(LCD_HEAVY_LOAD_PROTECT_O))
    else $error("lcd bit changed");

  // ****************************************************************
  // reset defaults
  // ****************************************************************
  // a reset edge leaves every control line at its default; these checks
  // must run while reset is high, so they switch the default disable off
  rst_core_hlp_a: assert property (disable iff (1'b0) SYS_RST_I |=>
    !CORE_HEAVY_LOAD_PROTECT_O) else $error("core protect not reset");
  rst_flash_a: assert property (disable iff (1'b0) SYS_RST_I |=>
    !FLASH_VOLTAGE_MODE_O) else $error("flash mode not reset");
  rst_lcd_hlp_a: assert property (disable iff (1'b0) SYS_RST_I |=>
    !LCD_HEAVY_LOAD_PROTECT_O) else $error("lcd protect not reset");
  rst_src_a: assert property (disable iff (1'b0) SYS_RST_I |=>
    !LCD_SOURCE_SELECT_O) else $error("source select not reset");
  rst_boost_a: assert property (disable iff (1'b0) SYS_RST_I |=>
    !BOOSTER_ON_O) else $error("booster not reset");
  // the bus handshake is also quiet after a reset edge
  rst_bus_a: assert property (disable iff (1'b0) SYS_RST_I |=>
    !ACK_O && DAT_O == 32'h00000000) else $error("bus not quiet after reset");

  // ****************************************************************
  // booster register hold
  // ****************************************************************
  // booster bits move only on a write to their own word
  src_hold_a: assert property (!(wr_en && hit_boost) |=>
    $stable(LCD_SOURCE_SELECT_O)) else $error("source select changed");
  boost_hold_a: assert property (!(wr_en && hit_boost) |=>
    $stable(BOOSTER_ON_O)) else $error("booster changed");
  // a write with byte lane 0 off is acknowledged but stores nothing
  lane_drop_a: assert property (req && WE_I && !lane0 |=>
    $stable(ctrl_r)) else $error("masked write stored");

  // ****************************************************************
  // read images
  // ****************************************************************
  // core word: protect bit at 4, flash mode at 0, rest zero
  core_read_a: assert property (req && !WE_I && hit_core |=>
    DAT_O[7:0] == {3'b000, CORE_HEAVY_LOAD_PROTECT_O, 3'b000, FLASH_VOLTAGE_MODE_O})
    else $error("core read wrong");
  // lcd word: protect bit at 4, rest zero
  lcd_read_a: assert property (req && !WE_I && hit_lcd |=>
    DAT_O[7:0] == {3'b000, LCD_HEAVY_LOAD_PROTECT_O, 4'h0})
    else $error("lcd read wrong");
  // booster word: booster on bit at 0
  boost_read_a: assert property (req && !WE_I && hit_boost |=>
    DAT_O[0] == BOOSTER_ON_O) else $error("booster bit read wrong");
  // words outside the map read as zero
  unmap_read_a: assert property (req && !WE_I && !hit_core && !hit_lcd && !hit_boost |=>
    DAT_O == 32'h00000000) else $error("unmapped read nonzero");

  // ****************************************************************
  // data bus quiet times
  // ****************************************************************
  // without ack the data bus stays at zero
  idle_data_a: assert property (!ACK_O |->
    DAT_O == 32'h00000000) else $error("data bus not idle");
  // a write answer carries no data
  write_data_a: assert property (req && WE_I |=>
    DAT_O == 32'h00000000) else $error("write answered with data");
  // ack only answers a strobe of the cycle before
  ack_cause_a: assert property (ACK_O |->
    $past(CYC_I && STB_I)) else $error("ack without request");

  cov_read_c:   cover property (ACK_O && DAT_O[PWRC_BOOST_ON_BIT]);
  cov_flash_c:  cover property (wr_en && hit_core && DAT_I[0]);
  cov_boost_c:  cover property (BOOSTER_ON_O ##[1:20] LCD_SOURCE_SELECT_O);
  cov_lcd_c:    cover property (wr_en && hit_lcd && DAT_I[4]);
  cov_unmap_c:  cover property (req && !hit_core && !hit_lcd && !hit_boost);
endmodule

// ===== pwrc_regs_bench.sv
// self-checking bench for the power control register bank
module pwrc_regs_bench
  import pwrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // design hookup and reference model
  // ****************************************************************
  logic                   clk, rst, cyc, stb, we, ack;
  logic [PWRC_ADDR_W-1:0] adr;
  logic [31:0]            dat_w, dat_r, q, wd;
  logic [3:0]             sel;
  logic [4:0]             outs;
  logic [PWRC_ADDR_W-1:0] adr_t [4] = '{18'h14480, 18'h1428C, 18'h14290, 18'h14294};
  logic [7:0]             msk   [4] = '{8'h11, 8'h10, 8'h03, 8'h00}; // reserved bits drop
  logic [7:0]             mdl   [4];
  int                     fail_count, samples_checked, seed, v, k;
  pwrc_regs uut (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .DAT_I(dat_w), .SEL_I(sel), .DAT_O(dat_r), .ACK_O(ack),
    .CORE_HEAVY_LOAD_PROTECT_O(outs[4]), .FLASH_VOLTAGE_MODE_O(outs[3]),
    .LCD_HEAVY_LOAD_PROTECT_O(outs[2]), .LCD_SOURCE_SELECT_O(outs[1]), .BOOSTER_ON_O(outs[0]));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] exp);
    samples_checked++;
    if (q !== exp) begin
      fail_count++;
      $display("[FAIL] %0t read %h expected %h", $time, q, exp);
    end
  endtask
  // control lines must mirror the model register bits
  task automatic chk_out();
    samples_checked++;
    if (outs !== {mdl[0][4], mdl[0][0], mdl[1][4], mdl[2][1], mdl[2][0]}) begin
      fail_count++;
      $display("[FAIL] %0t control lines %b", $time, outs);
    end
  endtask
  // classic single cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input int i, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= adr_t[i];
    dat_w <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_r;
    if (n >= 20) begin
      fail_count++;
      $display("[FAIL] %0t bus timeout", $time);
      results();
    end
    if (w && s[0]) mdl[i] = d[7:0] & msk[i];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst, cyc, stb, we, adr, dat_w, sel} = '0;
    rst = 1'b1;
    seed = 32'hfde2b71a;
    fail_count = 0;
    samples_checked = 0;
    mdl = '{default: 8'h00};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 4; k++) begin
      wb(1'b0, k, 32'h0, 4'hF);
      chk_rd({24'h0, mdl[k]});
    end
    chk_out();
    // booster first, then boosted source, then back to main supply
    wb(1'b1, 2, 32'h01, 4'h1);
    chk_out();
    wb(1'b1, 2, 32'h03, 4'h1);
    chk_out();
    wb(1'b1, 2, 32'h00, 4'h1);
    chk_out();
    // random writes of the mapped bits only, random byte enables and an unmapped slot
    for (k = 0; k < 60; k++) begin
      v = $random(seed);
      wd = v & {24'h000000, msk[v[5:4]]};
      if (v[5:4] == 2'd2 && wd[1] && !(mdl[2][0] && wd[0])) wd[1] = 1'b0;
      wb(1'b1, v[5:4], wd, v[11:8]);
      chk_out();
      wb(1'b0, v[5:4], 32'h0, 4'hF);
      chk_rd({24'h0, mdl[v[5:4]]});
    end
    // reset in mid-run clears every control line
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    mdl = '{default: 8'h00};
    @(posedge clk);
    chk_out();
    results();
  end
endmodule
